// ===== hw/epr_pkg.sv
// shared constants for the event poll response builder
package epr_pkg;
    // request operation selector codes
    localparam logic [7:0] OP_FOLLOWING_CHUNK = 8'h00;
    localparam logic [7:0] OP_FIRST_CHUNK = 8'h01;
    localparam logic [7:0] OP_ACK_ONLY = 8'h02;
    // result codes
    localparam logic [7:0] RC_SUCCESS = 8'h00;
    localparam logic [7:0] RC_INVALID_DATA = 8'h02;
    localparam logic [7:0] RC_BAD_CHUNK_HANDLE = 8'h80;
    // special event identifiers
    localparam logic [15:0] IDENT_NONE = 16'h0000;
    localparam logic [15:0] IDENT_MORE = 16'hffff;
    // chunk position codes
    localparam logic [7:0] POS_FIRST = 8'h00;
    localparam logic [7:0] POS_MIDDLE = 8'h01;
    localparam logic [7:0] POS_LAST = 8'h04;
    localparam logic [7:0] POS_SINGLE = 8'h05;
    // request frame: format, selector, handle(4), ack ident(2)
    localparam int REQ_BYTES = 8;
    localparam logic [2:0] REQ_LAST_IDX = 3'h7;
    // response lengths in bytes
    localparam logic [4:0] RSP_LEN_ERR = 5'h01;
    localparam logic [4:0] RSP_LEN_SHORT = 5'h04;
    localparam logic [4:0] RSP_LEN_FULL = 5'h0e;
    localparam logic [4:0] RSP_LEN_CRC = 5'h12;
    localparam int RSP_BITS = 144;
    // default largest payload chunk, in bytes
    localparam logic [31:0] CHUNK_BYTES_DEF = 32'h0000_0040;
    // control state after reset
    localparam logic [31:0] HANDLE_RST = 32'h0000_0000;
endpackage : epr_pkg

// ===== hw/epr_req_deser.sv
// request byte collector: gathers one poll request, least significant byte first
`timescale 1ns/1ps
module epr_req_deser (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [7:0] in_data_i,
    input wire logic in_last_i,
    input wire logic accept_i,
    output logic in_ready_o,
    output logic req_valid_o,
    output logic [7:0] op_selector_o,
    output logic [31:0] req_chunk_handle_o,
    output logic [15:0] ack_event_ident_o
);
    typedef struct packed {
        logic [63:0] sh;
        logic [2:0] idx;
        logic done;
    } epr_deser_t;

    epr_deser_t s_q;
    epr_deser_t s_d;

    assign in_ready_o = accept_i;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (in_valid_i && accept_i) begin
            s_d.sh = {in_data_i, s_q.sh[63:8]};
            s_d.idx = s_q.idx + 3'h1;
            // frames whose length is not a multiple of eight are dropped whole and resync on the last flag
            if (in_last_i) begin
                s_d.idx = 3'h0;
                s_d.done = (s_q.idx == epr_pkg::REQ_LAST_IDX);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // field 0 (format) is not checked here
    assign req_valid_o = s_q.done;
    assign op_selector_o = s_q.sh[15:8];
    assign req_chunk_handle_o = s_q.sh[47:16];
    assign ack_event_ident_o = s_q.sh[63:48];
endmodule : epr_req_deser

// ===== hw/epr_poll_responder.sv
// poll-for-event command interpreter: request in, response bytes out
//
// Contract
// - The incoming chunk handle is ignored for first-chunk and ack-only requests.
// - Result code 0x80 is returned when a following-chunk handle is not valid while the queue holds an event; with an empty queue the answer is ident 0x0000.
// - Every success response carries the one-byte endpoint ident; error responses are the result code alone.
// - Each returned event carries an ident that the controller can echo to acknowledge it.
// - An empty event queue is reported as event ident 0x0000.
// - An ack-only request with events still queued reports event ident 0xffff.
// - Chunk position is 0x00 first, 0x01 middle, 0x04 last, 0x05 single chunk.
// - With ident 0x0000 or 0xffff the handle, position, kind and size fields are left out.
// - The payload byte count is the 32-bit length of this chunk without the checksum.
// - A 32-bit following chunk handle names the next portion of the transfer.
// - A one-byte event kind names the type of the returned event.
// - Selector codes are 0x00 following chunk, 0x01 first chunk, 0x02 ack only.
// - An acknowledged event ident removes that event from the queue when it is the queue head.
// - The last chunk of a multipart event carries the 32-bit checksum of all its data.
`timescale 1ns/1ps
module epr_poll_responder #(
    parameter logic [31:0] CHUNK_BYTES = epr_pkg::CHUNK_BYTES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] endpoint_ident_i,
    // request byte stream
    input wire logic in_valid_i,
    input wire logic [7:0] in_data_i,
    input wire logic in_last_i,
    output logic in_ready_o,
    // response byte stream
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_last_o,
    input wire logic out_ready_i,
    // head of the event queue
    input wire logic queue_empty_i,
    input wire logic [15:0] head_event_ident_i,
    input wire logic [7:0] head_event_kind_i,
    input wire logic [31:0] head_total_bytes_i,
    input wire logic [31:0] head_checksum_i,
    output logic queue_pop_o,
    // chunk handed out by the last response
    output logic chunk_valid_o,
    output logic [31:0] chunk_offset_o,
    output logic [31:0] chunk_bytes_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_POP = 4'b0010,
        ST_BUILD = 4'b0100,
        ST_SEND = 4'b1000
    } epr_state_t;

    typedef struct packed {
        epr_state_t st;
        logic [epr_pkg::RSP_BITS-1:0] sh;
        logic [4:0] left;
        logic [7:0] op;
        logic [31:0] handle;
        logic pop;
        logic active;
        logic [15:0] active_ident;
        logic [31:0] expect_handle;
        logic chunk_valid;
        logic [31:0] chunk_off;
        logic [31:0] chunk_len;
    } epr_resp_t;

    epr_resp_t s_q;
    epr_resp_t s_d;

    logic req_valid;
    logic [7:0] req_op;
    logic [31:0] req_handle;
    logic [15:0] req_ack;

    epr_req_deser u_deser (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(in_valid_i),
        .in_data_i(in_data_i),
        .in_last_i(in_last_i),
        .accept_i(s_q.st == ST_IDLE),
        .in_ready_o(in_ready_o),
        .req_valid_o(req_valid),
        .op_selector_o(req_op),
        .req_chunk_handle_o(req_handle),
        .ack_event_ident_o(req_ack)
    );

    // chunk position code from first/last
    function automatic logic [7:0] pos_code(input logic first, input logic last);
        logic [7:0] c;
        c = epr_pkg::POS_MIDDLE;
        if (first && last) begin
            c = epr_pkg::POS_SINGLE;
        end else if (first) begin
            c = epr_pkg::POS_FIRST;
        end else if (last) begin
            c = epr_pkg::POS_LAST;
        end
        return c;
    endfunction : pos_code

    logic [31:0] off;
    logic [31:0] remain;
    logic [31:0] clen;
    logic is_first;
    logic is_last;
    logic handle_ok;

    always_comb begin
        // first-chunk starts at zero whatever handle was sent
        off = (s_q.op == epr_pkg::OP_FIRST_CHUNK) ? epr_pkg::HANDLE_RST : s_q.handle;
        remain = head_total_bytes_i - off;
        clen = (remain > CHUNK_BYTES) ? CHUNK_BYTES : remain;
        is_first = (off == epr_pkg::HANDLE_RST);
        is_last = (remain <= CHUNK_BYTES);
        // a handle is good only for the event in transfer, at the offset handed out
        handle_ok = s_q.active && !queue_empty_i && (head_event_ident_i == s_q.active_ident)
            && (s_q.handle == s_q.expect_handle) && (s_q.handle < head_total_bytes_i);
    end

    always_comb begin
        s_d = s_q;
        s_d.pop = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (req_valid) begin
                    s_d.op = req_op;
                    s_d.handle = req_handle;
                    // 0x0000 and 0xffff acknowledge nothing
                    s_d.pop = (req_ack != epr_pkg::IDENT_NONE) && (req_ack != epr_pkg::IDENT_MORE)
                        && !queue_empty_i && (req_ack == head_event_ident_i);
                    if (s_d.pop) begin
                        s_d.active = 1'b0;
                    end
                    s_d.st = ST_POP;
                end
            end
            // one spare cycle so the queue head settles after a removal
            ST_POP: begin
                s_d.st = ST_BUILD;
            end
            ST_BUILD: begin
                s_d.sh = '0;
                s_d.sh[15:8] = endpoint_ident_i;
                s_d.left = epr_pkg::RSP_LEN_SHORT;
                s_d.chunk_valid = 1'b0;
                s_d.st = ST_SEND;
                s_d.sh[7:0] = epr_pkg::RC_SUCCESS;
                unique case (s_q.op)
                    epr_pkg::OP_ACK_ONLY: begin
                        s_d.sh[31:16] = queue_empty_i ? epr_pkg::IDENT_NONE
                            : epr_pkg::IDENT_MORE;
                    end
                    epr_pkg::OP_FIRST_CHUNK, epr_pkg::OP_FOLLOWING_CHUNK: begin
                        if (queue_empty_i) begin
                            s_d.sh[31:16] = epr_pkg::IDENT_NONE;
                            s_d.active = 1'b0;
                        end else if (s_q.op == epr_pkg::OP_FOLLOWING_CHUNK && !handle_ok) begin
                            s_d.sh[7:0] = epr_pkg::RC_BAD_CHUNK_HANDLE;
                            s_d.left = epr_pkg::RSP_LEN_ERR;
                        end else begin
                            s_d.sh[31:16] = head_event_ident_i;
                            s_d.sh[63:32] = is_last ? epr_pkg::HANDLE_RST : off + clen;
                            s_d.sh[71:64] = pos_code(is_first, is_last);
                            s_d.sh[79:72] = head_event_kind_i;
                            s_d.sh[111:80] = clen;
                            s_d.sh[143:112] = head_checksum_i;
                            s_d.left = (is_last && !is_first) ? epr_pkg::RSP_LEN_CRC
                                : epr_pkg::RSP_LEN_FULL;
                            s_d.active = !is_last;
                            s_d.active_ident = head_event_ident_i;
                            s_d.expect_handle = off + clen;
                            s_d.chunk_valid = 1'b1;
                            s_d.chunk_off = off;
                            s_d.chunk_len = clen;
                        end
                    end
                    default: begin
                        s_d.sh[7:0] = epr_pkg::RC_INVALID_DATA;
                        s_d.left = epr_pkg::RSP_LEN_ERR;
                    end
                endcase
            end
            ST_SEND: begin
                if (out_ready_i) begin
                    s_d.sh = {8'h00, s_q.sh[epr_pkg::RSP_BITS-1:8]};
                    s_d.left = s_q.left - 5'h01;
                    if (s_q.left == 5'h01) begin
                        s_d.st = ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{st: ST_IDLE, expect_handle: epr_pkg::HANDLE_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign out_valid_o = (s_q.st == ST_SEND);
    assign out_data_o = s_q.sh[7:0];
    assign out_last_o = (s_q.st == ST_SEND) && (s_q.left == 5'h01);
    assign queue_pop_o = s_q.pop;
    assign chunk_valid_o = s_q.chunk_valid;
    assign chunk_offset_o = s_q.chunk_off;
    assign chunk_bytes_o = s_q.chunk_len;
endmodule : epr_poll_responder

// ===== tb/epr_poll_monitor.sv
// port assertions for the poll responder
`timescale 1ns/1ps
module epr_poll_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] endpoint_ident_i,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire logic [7:0] out_data_o,
    input wire logic out_last_o,
    input wire logic out_ready_i,
    input wire logic queue_empty_i,
    input wire logic queue_pop_o
);
    logic [4:0] idx_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take_last;
        out_valid_o && out_ready_i && out_last_o;
    endsequence
    sequence s_back_idle;
        !out_valid_o && in_ready_o;
    endsequence
    // byte position inside the current response
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) idx_q <= 5'h00;
        else if (out_valid_o && out_ready_i) idx_q <= out_last_o ? 5'h00 : idx_q + 5'h01;
    end
    a_pop_one_cycle: assert property (queue_pop_o |=> !queue_pop_o)
        else $error("pop longer than one cycle");
    a_pop_needs_entry: assert property (queue_pop_o |-> !queue_empty_i && !in_ready_o)
        else $error("pop with empty queue or while idle");
    a_rsp_holds: assert property (out_valid_o && !out_ready_i |=>
        out_valid_o && $stable(out_data_o) && $stable(out_last_o))
        else $error("response byte changed before taken");
    a_busy_no_req: assert property (out_valid_o |-> !in_ready_o)
        else $error("request accepted while answering");
    a_code_legal: assert property ($rose(out_valid_o) |-> out_data_o inside {8'h00, 8'h02, 8'h80})
        else $error("unexpected result code");
    a_error_short: assert property ($rose(out_valid_o) && out_data_o != 8'h00 |-> out_last_o)
        else $error("error response longer than one byte");
    a_ident_byte: assert property (out_valid_o && idx_q == 5'h01 |-> out_data_o == endpoint_ident_i)
        else $error("endpoint ident not in byte one");
    a_length_legal: assert property (out_valid_o && out_last_o |->
        idx_q inside {5'h00, 5'h03, 5'h0d, 5'h11})
        else $error("response length illegal");
    a_idle_after: assert property (s_take_last |=> s_back_idle)
        else $error("not idle after last byte");
endmodule : epr_poll_monitor
bind epr_poll_responder epr_poll_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .endpoint_ident_i(endpoint_ident_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .out_last_o(out_last_o), .out_ready_i(out_ready_i),
    .queue_empty_i(queue_empty_i), .queue_pop_o(queue_pop_o));

// ===== tb/epr_queue_model.sv
// event queue model with one short and one multipart event
`timescale 1ns/1ps
module epr_queue_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pop_i,
    output logic empty_o,
    output logic [15:0] ident_o,
    output logic [7:0] kind_o,
    output logic [31:0] total_o,
    output logic [31:0] sum_o
);
    logic [1:0] head_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) head_q <= 2'h0;
        else if (pop_i && !empty_o) head_q <= head_q + 2'h1;
    end
    // once empty the head fields show junk, so a design must not trust them
    always_comb begin
        empty_o = (head_q == 2'h2);
        ident_o = (head_q == 2'h1) ? 16'h0033 : 16'h0011;
        kind_o = (head_q == 2'h1) ? 8'h44 : 8'h22;
        total_o = (head_q == 2'h1) ? 32'h0000_000a : 32'h0000_0003;
        sum_o = (head_q == 2'h1) ? 32'h5a6b_7c8d : 32'hffff_ffff;
    end
endmodule : epr_queue_model

// ===== tb/test_event_poll_response_builder.sv
// directed bench for the poll responder
`timescale 1ns/1ps
module test_event_poll_response_builder;
    localparam logic [7:0] EP_IDENT = 8'h5c;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic in_valid_i = 1'b0;
    logic [7:0] in_data_i = 8'h00;
    logic in_last_i = 1'b0;
    logic out_ready_i = 1'b0;
    logic in_ready_o, out_valid_o, out_last_o, queue_pop_o, queue_empty_i, chunk_valid;
    logic [7:0] out_data_o, kind;
    logic [15:0] ident;
    logic [31:0] total, sum, chunk_off, chunk_len;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    always #10 clk_i = ~clk_i;
    epr_poll_responder #(.CHUNK_BYTES(32'h0000_0004)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .endpoint_ident_i(EP_IDENT), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
        .in_last_i(in_last_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
        .out_data_o(out_data_o), .out_last_o(out_last_o), .out_ready_i(out_ready_i),
        .queue_empty_i(queue_empty_i), .head_event_ident_i(ident), .head_event_kind_i(kind),
        .head_total_bytes_i(total), .head_checksum_i(sum), .queue_pop_o(queue_pop_o),
        .chunk_valid_o(chunk_valid), .chunk_offset_o(chunk_off), .chunk_bytes_o(chunk_len));
    epr_queue_model u_queue (.clk_i(clk_i), .rst_i(rst_i), .pop_i(queue_pop_o),
        .empty_o(queue_empty_i), .ident_o(ident), .kind_o(kind), .total_o(total), .sum_o(sum));
    task automatic conclude();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // chunk window left behind by the last response; offset and length hold when no chunk
    task automatic chk_chunk(input logic v, input logic [31:0] o, input logic [31:0] l);
        chk({31'h0, chunk_valid}, {31'h0, v});
        chk(chunk_off, o);
        chk(chunk_len, l);
    endtask : chk_chunk
    // one request frame, then the whole answer with the sink stalling every other cycle
    task automatic poll(input logic [7:0] op, input logic [31:0] h, input logic [15:0] ack,
                        input logic [7:0] e[$]);
        logic [63:0] f;
        logic [7:0] g[$];
        logic done;
        f = {ack, h, op, 8'h01};
        done = 1'b0;
        for (int i = 0; i < 8; i++) begin
            in_valid_i = 1'b1;
            in_data_i = f[8*i +: 8];
            in_last_i = (i == 7);
            while (in_ready_o !== 1'b1) begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
            #1;
        end
        in_valid_i = 1'b0;
        in_last_i = 1'b0;
        for (int c = 0; c < 200 && !done; c++) begin
            out_ready_i = c[0];
            if (out_valid_o === 1'b1 && out_ready_i) begin
                g.push_back(out_data_o);
                done = (out_last_o === 1'b1);
            end
            @(posedge clk_i);
            #1;
        end
        chk(g.size(), e.size());
        for (int i = 0; i < e.size() && i < g.size(); i++) chk(g[i], e[i]);
    endtask : poll
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        poll(8'h07, 32'h0, 16'h0000, '{8'h02});
        chk_chunk(1'b0, 32'h0, 32'h0);
        poll(8'h00, 32'h4, 16'hffff, '{8'h80});
        poll(8'h01, 32'hdeadbeef, 16'h0000, '{8'h00, EP_IDENT, 8'h11, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h05, 8'h22, 8'h03, 8'h00, 8'h00, 8'h00});
        chk_chunk(1'b1, 32'h0, 32'h3);
        poll(8'h02, 32'hffffffff, 16'h0011, '{8'h00, EP_IDENT, 8'hff, 8'hff});
        poll(8'h01, 32'h0, 16'h0000, '{8'h00, EP_IDENT, 8'h33, 8'h00, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h44, 8'h04, 8'h00, 8'h00, 8'h00});
        chk_chunk(1'b1, 32'h0, 32'h4);
        poll(8'h00, 32'h4, 16'hffff, '{8'h00, EP_IDENT, 8'h33, 8'h00, 8'h08, 8'h00, 8'h00,
            8'h00, 8'h01, 8'h44, 8'h04, 8'h00, 8'h00, 8'h00});
        chk_chunk(1'b1, 32'h4, 32'h4);
        poll(8'h00, 32'h8, 16'hffff, '{8'h00, EP_IDENT, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h04, 8'h44, 8'h02, 8'h00, 8'h00, 8'h00, 8'h8d, 8'h7c, 8'h6b,
            8'h5a});
        chk_chunk(1'b1, 32'h8, 32'h2);
        poll(8'h02, 32'h0, 16'h0033, '{8'h00, EP_IDENT, 8'h00, 8'h00});
        poll(8'h01, 32'h0, 16'h0000, '{8'h00, EP_IDENT, 8'h00, 8'h00});
        chk_chunk(1'b0, 32'h8, 32'h2);
        conclude();
    end
endmodule : test_event_poll_response_builder
